/* File: rtl/radio_timecode_decoder.sv */
// Radio timecode decoder with APB registers and interrupt
`timescale 1ns/1ps
`default_nettype none

module radio_timecode_decoder #(
  parameter int unsigned POL_WINDOW_CYC = radio_timecode_pkg::POL_WINDOW_CYC,
  parameter int unsigned SECOND_CYC     = radio_timecode_pkg::SECOND_CYC,
  parameter int unsigned FREE_TICK_CYC  = radio_timecode_pkg::FREE_TICK_CYC,
  parameter int unsigned MARKER_GAP_CYC = radio_timecode_pkg::MARKER_GAP_CYC,
  parameter int unsigned BIT_SPLIT_CYC  = radio_timecode_pkg::BIT_SPLIT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Timecode pin
  input  wire logic        timecode_in,
  // Status outputs
  output logic             irq,
  output logic             time_valid,
  output logic             leap_pending_flag,
  output logic             leap_sign_flag,
  output logic [1:0]       summer_time_indication
);

  // Timer ordering the logic depends on
  if (POL_WINDOW_CYC < 4) begin : g_chk_window
    $error("radio_timecode_decoder: polarity window too short");
  end

  // Duty judged over whole seconds, not a fraction of one
  if (POL_WINDOW_CYC < SECOND_CYC) begin : g_chk_window_sec
    $error("radio_timecode_decoder: polarity window below one second");
  end

  if (BIT_SPLIT_CYC < 1) begin : g_chk_split
    $error("radio_timecode_decoder: bit split below one cycle");
  end

  if (SECOND_CYC <= BIT_SPLIT_CYC) begin : g_chk_second
    $error("radio_timecode_decoder: second not above bit split");
  end

  // Long pulse lasts a fifth of a second
  if (5 * BIT_SPLIT_CYC >= SECOND_CYC) begin : g_chk_split_max
    $error("radio_timecode_decoder: bit split not below long pulse");
  end

  // A late marker must not count the second twice
  if (FREE_TICK_CYC <= SECOND_CYC) begin : g_chk_tick
    $error("radio_timecode_decoder: free tick not above one second");
  end

  if (MARKER_GAP_CYC <= FREE_TICK_CYC) begin : g_chk_gap
    $error("radio_timecode_decoder: marker gap not above free tick");
  end

  // Absent marker leaves a gap of two seconds only
  if (MARKER_GAP_CYC >= 2 * SECOND_CYC) begin : g_chk_gap_max
    $error("radio_timecode_decoder: marker gap not below two seconds");
  end

  radio_timecode_pkg::state_t q;
  radio_timecode_pkg::state_t n;

  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      radio_timecode_pkg::OFF_CTRL,
      radio_timecode_pkg::OFF_STATUS,
      radio_timecode_pkg::OFF_IRQ_STAT,
      radio_timecode_pkg::OFF_IRQ_MASK,
      radio_timecode_pkg::OFF_TIME,
      radio_timecode_pkg::OFF_DATE,
      radio_timecode_pkg::OFF_FLAGS,
      radio_timecode_pkg::OFF_STAMP,
      radio_timecode_pkg::OFF_SECONDS: addr_hit = 1'b1;
      default:                         addr_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [5:0] next_sec(input logic [5:0] s);
    next_sec = (s == radio_timecode_pkg::LAST_SEC) ? 6'h00 : s + 6'h01;
  endfunction

  function automatic radio_timecode_pkg::decoded_t
      decode_frame(input logic [radio_timecode_pkg::FRAME_BITS-1:0] f);
    radio_timecode_pkg::decoded_t d;
    logic [1:0]                   ind;
    d        = '0;
    d.minute = f[radio_timecode_pkg::BIT_MIN +: 7];
    d.hour   = f[radio_timecode_pkg::BIT_HOUR +: 6];
    d.day    = f[radio_timecode_pkg::BIT_DAY +: 6];
    d.wday   = f[radio_timecode_pkg::BIT_WDAY +: 3];
    d.month  = f[radio_timecode_pkg::BIT_MON +: 5];
    d.year   = f[radio_timecode_pkg::BIT_YEAR +: 8];
    d.leap_pending_flag = f[radio_timecode_pkg::BIT_LEAP];
    d.dst_pending = f[radio_timecode_pkg::BIT_DST_PND];
    if (f[radio_timecode_pkg::BIT_SUMMER]) begin
      ind = 2'h2;
    end else if (f[radio_timecode_pkg::BIT_WINTER]) begin
      ind = 2'h1;
    end else begin
      ind = 2'h0;
    end
    d.summer_time_indication = ind;
    // offset is minus the zone hours
    d.utc_offset = 4'h0 - {2'h0, ind};
    decode_frame = d;
  endfunction

  always_comb begin
    logic                     lvl;
    logic                     rise;
    logic                     fall;
    logic                     act;
    logic                     opp;
    logic                     new_inv;
    logic                     missing;
    logic                     run;
    logic [radio_timecode_pkg::NUM_EV-1:0] ev;
    logic [radio_timecode_pkg::NUM_EV-1:0] clr;
    lvl     = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    act     = 1'b0;
    opp     = 1'b0;
    new_inv = 1'b0;
    missing = 1'b0;
    run     = 1'b0;
    ev      = '0;
    clr     = '0;
    n       = q;

    n.sync  = {q.sync[0], timecode_in};
    lvl     = q.sync[1];
    n.level = lvl;
    rise    = lvl & ~q.level;
    fall    = ~lvl & q.level;
    act     = q.inv ? fall : rise;
    opp     = q.inv ? rise : fall;
    run     = q.ctrl[radio_timecode_pkg::CTRL_EN];
    n.tick  = q.tick + 32'h1;

    // high time over half the window means inverted
    if (q.win_cnt == 32'(POL_WINDOW_CYC - 1)) begin
      n.win_cnt  = '0;
      n.high_cnt = '0;
      new_inv    = q.ctrl[radio_timecode_pkg::CTRL_AUTO] &
                   (q.high_cnt > 32'(POL_WINDOW_CYC / 2));
      if (new_inv != q.inv) begin
        n.inv                                = new_inv;
        ev[radio_timecode_pkg::EV_POLARITY] = 1'b1;
      end
    end else begin
      n.win_cnt  = q.win_cnt + 32'h1;
      n.high_cnt = q.high_cnt + {31'h0, lvl};
    end

    if (q.gap_cnt != 32'hffff_ffff) begin
      n.gap_cnt = q.gap_cnt + 32'h1;
    end
    if (q.in_pulse) begin
      n.width_cnt = q.width_cnt + 32'h1;
    end

    if (opp && q.in_pulse) begin
      n.in_pulse = 1'b0;
      if ((q.st == radio_timecode_pkg::ST_DECODE || q.st == radio_timecode_pkg::ST_LOCKED) &&
          q.sec_cnt < 6'(radio_timecode_pkg::FRAME_BITS)) begin
        n.frame[q.sec_cnt] = (q.width_cnt >= 32'(BIT_SPLIT_CYC));
      end
    end

    // free running second without any marker
    if (q.st != radio_timecode_pkg::ST_IDLE && !act) begin
      if (q.sec_tmr == 32'(FREE_TICK_CYC - 1)) begin
        n.sec_tmr                          = 32'(FREE_TICK_CYC - SECOND_CYC);
        n.sec_cnt                          = next_sec(q.sec_cnt);
        n.free_adv                         = 1'b1;
        ev[radio_timecode_pkg::EV_SECOND] = 1'b1;
      end else begin
        n.sec_tmr = q.sec_tmr + 32'h1;
      end
    end

    if (act && run) begin
      // stamp taken from the marker edge
      n.stamp     = q.tick;
      n.width_cnt = '0;
      n.in_pulse  = 1'b1;
      n.gap_cnt   = '0;
      n.sec_tmr   = '0;
      n.free_adv  = 1'b0;
      // long gap marks the absent second
      missing     = q.gap_cnt >= 32'(MARKER_GAP_CYC);
      case (q.st)
        radio_timecode_pkg::ST_IDLE: begin
          n.st                               = radio_timecode_pkg::ST_FREE;
          n.sec_cnt                          = '0;
          ev[radio_timecode_pkg::EV_SECOND] = 1'b1;
        end
        radio_timecode_pkg::ST_FREE: begin
          if (missing) begin
            // align on minute start and decode
            n.st                                = radio_timecode_pkg::ST_DECODE;
            n.sec_cnt                           = '0;
            n.frame                             = '0;
            ev[radio_timecode_pkg::EV_MISSING] = 1'b1;
          end else if (!q.free_adv) begin
            n.sec_cnt = next_sec(q.sec_cnt);
          end
          ev[radio_timecode_pkg::EV_SECOND] = 1'b1;
        end
        radio_timecode_pkg::ST_DECODE,
        radio_timecode_pkg::ST_LOCKED: begin
          if (missing) begin
            // publish at the 59 to 00 change
            n.dec                               = decode_frame(q.frame);
            n.valid                             = 1'b1;
            n.st                                = radio_timecode_pkg::ST_LOCKED;
            n.sec_cnt                           = '0;
            n.frame                             = '0;
            ev[radio_timecode_pkg::EV_MINUTE]  = 1'b1;
            ev[radio_timecode_pkg::EV_MISSING] = 1'b1;
          end else if (!q.free_adv) begin
            n.sec_cnt = next_sec(q.sec_cnt);
          end
          ev[radio_timecode_pkg::EV_SECOND] = 1'b1;
        end
        default: begin
          n.st = radio_timecode_pkg::ST_IDLE;
        end
      endcase
    end

    // Register writes in the access phase
    if (psel && penable && pwrite) begin
      case (paddr)
        radio_timecode_pkg::OFF_CTRL: begin
          n.ctrl = pwdata[1:0];
        end
        radio_timecode_pkg::OFF_IRQ_STAT: begin
          clr = pwdata[radio_timecode_pkg::NUM_EV-1:0];
        end
        radio_timecode_pkg::OFF_IRQ_MASK: begin
          n.irq_mask = pwdata[radio_timecode_pkg::NUM_EV-1:0];
        end
        default: begin
          clr = '0;
        end
      endcase
    end
    // Set beats clear so no event is lost
    n.irq_stat = (q.irq_stat & ~clr) | ev;

    // Read data captured in setup so it is a flop in the access phase
    if (psel && !penable) begin
      case (paddr)
        radio_timecode_pkg::OFF_CTRL:     n.prdata = {30'h0, q.ctrl};
        radio_timecode_pkg::OFF_STATUS:   n.prdata = {28'h0, q.st, q.inv, q.valid};
        radio_timecode_pkg::OFF_IRQ_STAT: n.prdata = {28'h0, q.irq_stat};
        radio_timecode_pkg::OFF_IRQ_MASK: n.prdata = {28'h0, q.irq_mask};
        // decoded fields stay zero until first publish
        radio_timecode_pkg::OFF_TIME:     n.prdata = {18'h0, q.dec.hour, 1'b0, q.dec.minute};
        radio_timecode_pkg::OFF_DATE:     n.prdata = {q.dec.year, 3'h0, q.dec.month, 5'h0,
                                                      q.dec.wday, 2'h0, q.dec.day};
        radio_timecode_pkg::OFF_FLAGS:    n.prdata = {20'h0, q.dec.utc_offset, 2'h0,
                                                      q.dec.summer_time_indication, 1'b0,
                                                      q.dec.dst_pending, 1'b0,
                                                      q.dec.leap_pending_flag};
        radio_timecode_pkg::OFF_STAMP:    n.prdata = q.stamp;
        radio_timecode_pkg::OFF_SECONDS:  n.prdata = {26'h0, q.sec_cnt};
        default:                          n.prdata = 32'h0;
      endcase
    end

    // Disabling drops sync; polarity tracking keeps going
    if (!run) begin
      n.st       = radio_timecode_pkg::ST_IDLE;
      n.valid    = 1'b0;
      n.dec      = '0;
      n.sec_cnt  = '0;
      n.sec_tmr  = '0;
      n.free_adv = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.st       <= radio_timecode_pkg::ST_IDLE;
      q.ctrl     <= radio_timecode_pkg::CTRL_RESET;
    end else begin
      q <= n;
    end
  end

  // Zero wait state slave
  assign pready                 = 1'b1;
  assign pslverr                = psel & penable & ~addr_hit(paddr);
  assign prdata                 = q.prdata;
  assign irq                    = |(q.irq_stat & q.irq_mask);
  assign time_valid             = q.valid;
  assign leap_pending_flag      = q.dec.leap_pending_flag;
  // sign is not carried in the code
  assign leap_sign_flag         = 1'b0;
  assign summer_time_indication = q.dec.summer_time_indication;

endmodule

`default_nettype wire

/* File: rtl/radio_timecode_pkg.sv */
// Constants, register map and types of the radio timecode decoder
package radio_timecode_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
  localparam int unsigned POL_WINDOW_MS  = 5000;
  localparam int unsigned SECOND_MS      = 1000;
  localparam int unsigned FREE_TICK_MS   = 1050;
  localparam int unsigned MARKER_GAP_MS  = 1500;
  localparam int unsigned BIT_SPLIT_MS   = 150;
  localparam int unsigned POL_WINDOW_CYC = POL_WINDOW_MS * CYC_PER_MS;
  localparam int unsigned SECOND_CYC     = SECOND_MS * CYC_PER_MS;
  localparam int unsigned FREE_TICK_CYC  = FREE_TICK_MS * CYC_PER_MS;
  localparam int unsigned MARKER_GAP_CYC = MARKER_GAP_MS * CYC_PER_MS;
  localparam int unsigned BIT_SPLIT_CYC  = BIT_SPLIT_MS * CYC_PER_MS;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFF_TIME     = 8'h10;
  localparam logic [7:0] OFF_DATE     = 8'h14;
  localparam logic [7:0] OFF_FLAGS    = 8'h18;
  localparam logic [7:0] OFF_STAMP    = 8'h1c;
  localparam logic [7:0] OFF_SECONDS  = 8'h20;

  // Control fields and reset
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_AUTO  = 1;
  localparam logic [1:0]  CTRL_RESET = 2'h3;

  // Interrupt events
  localparam int unsigned NUM_EV      = 4;
  localparam int unsigned EV_SECOND   = 0;
  localparam int unsigned EV_MINUTE   = 1;
  localparam int unsigned EV_POLARITY = 2;
  localparam int unsigned EV_MISSING  = 3;

  // Positions inside a received minute
  localparam int unsigned FRAME_BITS  = 59;
  localparam logic [5:0]  LAST_SEC    = 6'h3b;
  localparam int unsigned BIT_DST_PND = 16;
  localparam int unsigned BIT_SUMMER  = 17;
  localparam int unsigned BIT_WINTER  = 18;
  localparam int unsigned BIT_LEAP    = 19;
  localparam int unsigned BIT_MIN     = 21;
  localparam int unsigned BIT_HOUR    = 29;
  localparam int unsigned BIT_DAY     = 36;
  localparam int unsigned BIT_WDAY    = 42;
  localparam int unsigned BIT_MON     = 45;
  localparam int unsigned BIT_YEAR    = 50;

  typedef enum logic [1:0] {ST_IDLE, ST_FREE, ST_DECODE, ST_LOCKED} dec_state_t;

  typedef struct packed {
    logic [6:0] minute;
    logic [5:0] hour;
    logic [5:0] day;
    logic [2:0] wday;
    logic [4:0] month;
    logic [7:0] year;
    logic       leap_pending_flag;
    logic       dst_pending;
    logic [1:0] summer_time_indication;
    logic [3:0] utc_offset;
  } decoded_t;

  typedef struct packed {
    logic [1:0]            sync;
    logic                  level;
    logic                  inv;
    logic [31:0]           win_cnt;
    logic [31:0]           high_cnt;
    logic [31:0]           gap_cnt;
    logic [31:0]           sec_tmr;
    logic [31:0]           width_cnt;
    logic                  in_pulse;
    logic                  free_adv;
    logic [5:0]            sec_cnt;
    logic [FRAME_BITS-1:0] frame;
    decoded_t              dec;
    logic                  valid;
    dec_state_t            st;
    logic [31:0]           tick;
    logic [31:0]           stamp;
    logic [1:0]            ctrl;
    logic [NUM_EV-1:0]     irq_stat;
    logic [NUM_EV-1:0]     irq_mask;
    logic [31:0]           prdata;
  } state_t;

endpackage

/* File: testbench/radio_timecode_chk.sv */
// Port checker for the radio timecode decoder
`timescale 1ns/1ps
`default_nettype none

module radio_timecode_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin and status
  input wire logic        timecode_in,
  input wire logic        time_valid,
  input wire logic        leap_pending_flag,
  input wire logic        leap_sign_flag,
  input wire logic [1:0]  summer_time_indication
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready;
    pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_phase;
    pslverr |-> psel && penable;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
  property p_err_map;
    psel && penable && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h20);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  property p_err_zero;
    psel && penable && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  property p_sign;
    !leap_sign_flag;
  endproperty
  a_sign: assert property (p_sign) else $error("leap sign set");
  property p_summer;
    summer_time_indication != 2'h3;
  endproperty
  a_summer: assert property (p_summer) else $error("summer code 3");
  property p_nosync;
    !time_valid |-> !leap_pending_flag && summer_time_indication == 2'h0;
  endproperty
  a_nosync: assert property (p_nosync) else $error("flags before sync");
  property p_publish;
    time_valid && ($rose(time_valid) || $changed(leap_pending_flag))
      |-> $past(timecode_in, 2) != $past(timecode_in, 7);
  endproperty
  a_publish: assert property (p_publish) else $error("publish off edge");
endmodule

bind radio_timecode_decoder radio_timecode_chk radio_timecode_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timecode_in(timecode_in),
  .time_valid(time_valid), .leap_pending_flag(leap_pending_flag),
  .leap_sign_flag(leap_sign_flag), .summer_time_indication(summer_time_indication)
);
`default_nettype wire

/* File: testbench/radio_timecode_decoder_tb_top.sv */
// Testbench top for the radio timecode decoder
`timescale 1ns/1ps
`default_nettype none

module radio_timecode_decoder_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        tc, irq, time_valid, leap_pending_flag, leap_sign_flag, run, inv;
  logic [1:0]  summer_time_indication;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, s1;
  logic [58:0] frame;
  int          fail_count, cmp_count;

  // Short counts keep a minute near 6000 cycles
  radio_timecode_decoder #(
    .POL_WINDOW_CYC(400), .SECOND_CYC(100), .FREE_TICK_CYC(105),
    .MARKER_GAP_CYC(150), .BIT_SPLIT_CYC(15)
  ) radio_timecode_decoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timecode_in(tc), .irq(irq), .time_valid(time_valid),
    .leap_pending_flag(leap_pending_flag), .leap_sign_flag(leap_sign_flag),
    .summer_time_indication(summer_time_indication)
  );
  timecode_source timecode_source_inst (
    .pclk(pclk), .run(run), .inv(inv), .frame(frame), .line(tc)
  );

  function automatic logic [58:0] mk(input logic [6:0] mi, input logic [3:0] fl);
    logic [58:0] f;
    f = '0;
    f[19:16] = fl;
    f[27:21] = mi;
    f[34:29] = 6'h15;
    f[41:36] = 6'h09;
    f[44:42] = 3'h2;
    f[49:45] = 5'h09;
    f[57:50] = 8'h08;
    return f;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(r, x);
  endtask

  // Active edge follows the polarity the bench applied
  task automatic act(input int n);
    if (inv) @(negedge tc);
    else @(posedge tc);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_regs;
    rd(8'h00, 32'h3);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0);
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(e), 32'h1);
    check(r, 32'h0);
  endtask

  task automatic t_free;
    run <= 1'b1;
    act(30);
    apb(1'b0, 8'h20, 32'h0);
    s1 = r;
    act(30);
    rd(8'h20, s1 + 32'h1);
    rd(8'h10, 32'h0);
    check(32'(time_valid), 32'h0);
    rd(8'h08, 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, 8'h0c, 32'h1);
    rd(8'h0c, 32'h1);
    check(32'(irq), 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    rd(8'h08, 32'h0);
    check(32'(irq), 32'h0);
  endtask

  task automatic t_decode;
    wait (time_valid === 1'b1);
    frame <= mk(7'h38, 4'h4);
    rd(8'h20, 32'h0);
    check(32'(time_valid), 32'h1);
    rd(8'h04, 32'hd);
    rd(8'h10, 32'h1537);
    rd(8'h14, 32'h0809_0209);
    rd(8'h18, 32'he25);
    rd(8'h08, 32'hb);
    check(32'(leap_pending_flag), 32'h1);
    check(32'(summer_time_indication), 32'h2);
    wait (summer_time_indication === 2'h1);
    rd(8'h10, 32'h1538);
    rd(8'h18, 32'hf10);
    check(32'(leap_pending_flag), 32'h0);
  endtask

  // First read lands before the passive edge, the second after it
  task automatic t_stamp;
    act(3);
    apb(1'b0, 8'h1c, 32'h0);
    s1 = r;
    repeat (25) @(posedge pclk);
    rd(8'h1c, s1);
    act(3);
    rd(8'h1c, s1 + 32'd100);
  endtask

  task automatic t_invert;
    inv <= 1'b1;
    repeat (900) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    check(r & 32'h2, 32'h2);
    apb(1'b0, 8'h08, 32'h0);
    check(r & 32'h4, 32'h4);
    t_stamp();
  endtask

  task automatic t_lost;
    run <= 1'b0;
    apb(1'b0, 8'h20, 32'h0);
    s1 = r;
    repeat (400) @(posedge pclk);
    apb(1'b0, 8'h20, 32'h0);
    check(32'(r != s1), 32'h1);
  endtask

  // Enable off drops sync; auto off restores normal polarity
  task automatic t_disable;
    apb(1'b1, 8'h00, 32'h0);
    rd(8'h10, 32'h0);
    check(32'(time_valid), 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h20, 32'h0);
    repeat (450) @(posedge pclk);
    rd(8'h04, 32'h0);
  endtask

  task automatic give_verdict;
    $display("mismatches=%0d compares=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    inv = 1'b0;
    frame = mk(7'h37, 4'hb);
    fail_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_free();
    t_decode();
    t_stamp();
    t_invert();
    t_lost();
    t_disable();
    give_verdict();
  end

  // About 20000 cycles expected; cut a hang at twice that
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: testbench/timecode_source.sv */
// Behavioural timecode receiver driving the decoder pin
`timescale 1ns/1ps
`default_nettype none

module timecode_source (
  // Clock
  input  wire logic        pclk,
  // Control
  input  wire logic        run,
  input  wire logic        inv,
  input  wire logic [58:0] frame,
  // Pin
  output logic             line
);
  logic [12:0] cyc_q;
  logic [5:0]  sec;
  logic [6:0]  ph;

  assign sec = 6'(cyc_q / 13'd100);
  assign ph  = 7'(cyc_q % 13'd100);

  always_ff @(posedge pclk) begin
    if (!run || cyc_q == 13'd5999) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 13'd1;
    end
  end

  // rising edge, 10 or 20 high; falling edge and 10 or 20 low when inv is set
  // Second 59 has no pulse, which marks the minute
  assign line = inv ^ (run && sec != 6'd59 && ph < (frame[sec] ? 7'd20 : 7'd10));
endmodule
`default_nettype wire
